/* File: design/atd_pkg.sv */
/*
 * constants for the audio / transport-stream dma channel: fifo shape,
 * instruction encoding, source modes, pci commands and input rates.
 * assumes a single 25 mhz clock shared by the whole channel.
 */
package atd_pkg;

    localparam int          CLK_MHZ        = 25;
    localparam int          SER_RATE_MBPS  = 40;
    localparam int          PAR_RATE_MBPS  = 20;
    // serial lane width needed to keep up with the serial rate
    localparam int          SER_LANES      = (SER_RATE_MBPS + CLK_MHZ - 1) / CLK_MHZ;

    localparam int          FIFO_DEPTH     = 35;
    localparam int          FIFO_WIDTH     = 36;
    localparam int          CNT_W          = 6;

    // source modes
    localparam logic [1:0]  MODE_AUDIO     = 2'h0;
    localparam logic [1:0]  MODE_SERIAL    = 2'h1;
    localparam logic [1:0]  MODE_PARALLEL  = 2'h2;

    // instruction word 0 fields
    localparam int          OP_HI          = 31;
    localparam int          OP_LO          = 28;
    localparam int          IRQ_BIT        = 24;
    localparam int          BCNT_HI        = 11;
    localparam int          BCNT_LO        = 0;

    // packed-mode opcodes
    localparam logic [3:0]  OP_WRITE       = 4'h1;
    localparam logic [3:0]  OP_JUMP        = 4'h7;
    localparam logic [3:0]  OP_HALT        = 4'h0;

    localparam logic [3:0]  PCI_MEM_WRITE  = 4'h7;
    localparam logic [3:0]  BYTES_ALL      = 4'h0;
    localparam logic [31:0] DWORD_STEP     = 32'h0000_0004;

endpackage

/* File: design/atd_packer.sv */
/*
 * packs audio samples, serial transport bits or parallel transport bytes
 * into little-endian dwords.
 * assumes only the input selected by mode is active.
 */
module atd_packer
    import atd_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic [1:0]           mode,
    input  wire logic                 smp_wide,
    input  wire logic [15:0]          smp_data,
    input  wire logic                 smp_valid,
    input  wire logic [SER_LANES-1:0] ser_data,
    input  wire logic                 ser_valid,
    input  wire logic [7:0]           par_data,
    input  wire logic                 par_valid,
    output logic [31:0]               word,
    output logic                      word_valid
);

    logic [31:0]          acc_r, acc_nxt;
    logic [1:0]           bpos_r, bpos_nxt;
    logic [7:0]           sbyte_r, sbyte_nxt;
    logic [2:0]           sbit_r, sbit_nxt;
    logic [31:0]          word_r, word_nxt;
    logic                 wv_r, wv_nxt;

    assign word       = word_r;
    assign word_valid = wv_r;

    always_comb begin
        logic [7:0]  b;
        logic        bv;
        logic [7:0]  sb;
        b         = 8'h00;
        bv        = 1'b0;
        sb        = 8'h00;
        acc_nxt   = acc_r;
        bpos_nxt  = bpos_r;
        sbyte_nxt = sbyte_r;
        sbit_nxt  = sbit_r;
        word_nxt  = word_r;
        wv_nxt    = 1'b0;
        // serial lanes shift in msb first, a byte at a time
        if (mode == MODE_SERIAL && ser_valid) begin
            sb        = 8'({sbyte_r, ser_data});
            sbyte_nxt = sb;
            sbit_nxt  = 3'(sbit_r + 3'(SER_LANES));
            if (sbit_nxt == 3'h0) begin
                b  = sb;
                bv = 1'b1;
            end
        end
        if (mode == MODE_PARALLEL && par_valid) begin
            b  = par_data;
            bv = 1'b1;
        end
        if (mode == MODE_AUDIO && smp_valid) begin
            if (smp_wide) begin
                acc_nxt[8*bpos_r +: 16] = smp_data;
                bpos_nxt                = 2'(bpos_r + 2'h2);
                if (bpos_r[1]) begin
                    word_nxt = {smp_data, acc_r[15:0]};
                    wv_nxt   = 1'b1;
                end
            end else begin
                b  = smp_data[15:8];
                bv = 1'b1;
            end
        end
        if (bv) begin
            acc_nxt[8*bpos_r +: 8] = b;
            bpos_nxt               = 2'(bpos_r + 2'h1);
            if (bpos_r == 2'h3) begin
                word_nxt = {b, acc_r[23:0]};
                wv_nxt   = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            acc_r   <= 32'h0000_0000;
            bpos_r  <= 2'h0;
            sbyte_r <= 8'h00;
            sbit_r  <= 3'h0;
            word_r  <= 32'h0000_0000;
            wv_r    <= 1'b0;
        end else begin
            acc_r   <= acc_nxt;
            bpos_r  <= bpos_nxt;
            sbyte_r <= sbyte_nxt;
            sbit_r  <= sbit_nxt;
            word_r  <= word_nxt;
            wv_r    <= wv_nxt;
        end
    end

endmodule // atd_packer

/* File: design/atd_dma_channel.sv */
/*
 * audio / transport-stream dma channel: instruction fetcher, 35 deep fifo,
 * pci memory-write initiator and a never-stalling target response.
 * assumes pci signals appear here active high and synchronous to clk;
 * pads and wire resolution live outside.
 */
// How it works
// - samples 8 or 16 bits, packed into dwords
// - instruction program fetched from host, packed mode
// - runs independent of any video traffic
// - continuous capture, no sync gaps
// - fifo 35 by 36, 6-bit dword counter
// - own retry handling, never blocks others
// - same dma interface and interrupt support
// - registers in bus domain, 32 bits wide
// - target never disconnects nor retries
// - target checks bus parity errors
// - transport packets travel through this channel
// - serial transport on audio pins, 40 mbps
// - parallel transport via gpio, 20 mbps
// - overrun resyncs at next data unit
module atd_dma_channel
    import atd_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int WIDTH = FIFO_WIDTH
)(
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 risc_run,
    input  wire logic                 risc_start,
    input  wire logic [31:0]          prog_base,
    input  wire logic [1:0]           mode,
    input  wire logic                 smp_wide,
    input  wire logic [15:0]          smp_data,
    input  wire logic                 smp_valid,
    input  wire logic [SER_LANES-1:0] ser_data,
    input  wire logic                 ser_valid,
    input  wire logic [7:0]           par_data,
    input  wire logic                 par_valid,
    output logic                      fetch_req,
    output logic [31:0]               fetch_addr,
    input  wire logic                 fetch_ack,
    input  wire logic [31:0]          fetch_data,
    output logic                      bus_req,
    input  wire logic                 bus_gnt,
    output logic                      frame_o,
    output logic                      irdy_o,
    output logic                      ctl_oe,
    output logic [31:0]               ad_o,
    output logic [3:0]                cbe_o,
    output logic                      ad_oe,
    input  wire logic                 trdy_i,
    input  wire logic                 stop_i,
    input  wire logic                 tgt_sel,
    input  wire logic [31:0]          tgt_ad_i,
    input  wire logic [3:0]           tgt_cbe_i,
    input  wire logic                 tgt_par_i,
    output logic                      tgt_trdy_o,
    output logic                      tgt_stop_o,
    output logic                      perr_o,
    output logic                      risc_irq,
    output logic                      overrun,
    output logic [CNT_W-1:0]          fifo_level,
    output logic                      busy
);

    typedef enum {
        ST_IDLE, ST_FETCH0, ST_FETCH1, ST_EXEC, ST_REQ, ST_ADDR, ST_DATA
    } atd_state_t;

    function automatic logic [CNT_W-1:0] ptr_inc(input logic [CNT_W-1:0] p);
        ptr_inc = (p == CNT_W'(DEPTH - 1)) ? '0 : CNT_W'(p + 1'b1);
    endfunction

    function automatic logic even_par(input logic [31:0] ad, input logic [3:0] cbe);
        even_par = ^{ad, cbe};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // packer

    logic [31:0] pk_word;
    logic        pk_valid;

    // one data path for audio, serial and parallel transport
    atd_packer u_packer (
        .clk        (clk),
        .srst       (srst),
        .mode       (mode),
        .smp_wide   (smp_wide),
        .smp_data   (smp_data),
        .smp_valid  (smp_valid),
        .ser_data   (ser_data),
        .ser_valid  (ser_valid),
        .par_data   (par_data),
        .par_valid  (par_valid),
        .word       (pk_word),
        .word_valid (pk_valid)
    );

    ////////////////////////////////////////////////////////////////////////
    // fifo

    logic [WIDTH-1:0]  mem_r [DEPTH];
    logic [CNT_W-1:0]  wp_r, wp_nxt, rp_r, rp_nxt, cnt_r, cnt_nxt;
    logic              ovr_r, ovr_nxt;
    logic              push, pop, full;

    assign full       = (cnt_r == CNT_W'(DEPTH));
    assign push       = pk_valid && !full;
    assign fifo_level = cnt_r;
    assign overrun    = ovr_r;

    always_comb begin
        wp_nxt  = push ? ptr_inc(wp_r) : wp_r;
        rp_nxt  = pop ? ptr_inc(rp_r) : rp_r;
        cnt_nxt = CNT_W'(cnt_r + CNT_W'(push) - CNT_W'(pop));
        // word dropped whole; next sample starts a fresh dword
        ovr_nxt = ovr_r && !risc_start;
        if (pk_valid && full) begin
            ovr_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= {4'h0, pk_word};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            ovr_r <= 1'b0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            ovr_r <= ovr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction sequencer and initiator

    atd_state_t   st_r, st_nxt;
    logic [31:0]  pc_r, pc_nxt, w0_r, w0_nxt, addr_r, addr_nxt, ad_r, ad_nxt;
    logic [9:0]   remain_r, remain_nxt;
    logic         irq_r, irq_nxt, fin_r, fin_nxt;
    logic         last;

    // last data phase when fifo or instruction runs out
    assign last = fin_r || (cnt_r == CNT_W'(1)) || (remain_r == 10'h001);
    assign pop  = (st_r == ST_DATA) && trdy_i;

    assign fetch_req  = (st_r == ST_FETCH0) || (st_r == ST_FETCH1);
    assign fetch_addr = pc_r;
    assign bus_req    = (st_r == ST_REQ);
    assign frame_o    = (st_r == ST_ADDR) || (st_r == ST_DATA && !last);
    assign irdy_o     = (st_r == ST_DATA);
    assign ctl_oe     = (st_r == ST_ADDR) || (st_r == ST_DATA);
    assign ad_oe      = ctl_oe;
    assign ad_o       = ad_r;
    assign cbe_o      = (st_r == ST_ADDR) ? PCI_MEM_WRITE : BYTES_ALL;
    assign risc_irq   = irq_r;
    assign busy       = (st_r != ST_IDLE);

    always_comb begin
        st_nxt     = st_r;
        pc_nxt     = pc_r;
        w0_nxt     = w0_r;
        addr_nxt   = addr_r;
        ad_nxt     = ad_r;
        remain_nxt = remain_r;
        irq_nxt    = 1'b0;
        // frame stays low once dropped, even if the fifo refills
        fin_nxt    = (st_r == ST_DATA) && last;
        case (st_r)
            ST_IDLE: begin
                if (risc_start && risc_run) begin
                    pc_nxt = prog_base;
                    st_nxt = ST_FETCH0;
                end
            end
            ST_FETCH0: begin
                if (fetch_ack) begin
                    w0_nxt = fetch_data;
                    pc_nxt = pc_r + DWORD_STEP;
                    st_nxt = ST_FETCH1;
                end
            end
            ST_FETCH1: begin
                if (fetch_ack) begin
                    addr_nxt   = fetch_data;
                    pc_nxt     = pc_r + DWORD_STEP;
                    remain_nxt = 10'((w0_r[BCNT_HI:BCNT_LO] + 12'h003) >> 2);
                    st_nxt     = ST_EXEC;
                end
            end
            ST_EXEC: begin
                case (w0_r[OP_HI:OP_LO])
                    OP_WRITE: begin
                        if (remain_r == 10'h000) begin
                            irq_nxt = w0_r[IRQ_BIT];
                            st_nxt  = ST_FETCH0;
                        end else if (cnt_r != '0) begin
                            st_nxt = ST_REQ;
                        end
                    end
                    OP_JUMP: begin
                        irq_nxt = w0_r[IRQ_BIT];
                        pc_nxt  = addr_r;
                        st_nxt  = ST_FETCH0;
                    end
                    OP_HALT: begin
                        irq_nxt = w0_r[IRQ_BIT];
                        st_nxt  = ST_IDLE;
                    end
                    default: begin
                        st_nxt = ST_FETCH0;
                    end
                endcase
                if (!risc_run) begin
                    st_nxt = ST_IDLE;
                end
            end
            ST_REQ: begin
                if (bus_gnt) begin
                    ad_nxt = addr_r;
                    st_nxt = ST_ADDR;
                end
            end
            ST_ADDR: begin
                ad_nxt = mem_r[rp_r][31:0];
                st_nxt = ST_DATA;
            end
            ST_DATA: begin
                if (trdy_i) begin
                    addr_nxt   = addr_r + DWORD_STEP;
                    remain_nxt = 10'(remain_r - 10'h001);
                    ad_nxt     = mem_r[rp_nxt][31:0];
                end
                if ((trdy_i && last) || stop_i) begin
                    // retry or disconnect handled locally; re-arbitrate later
                    st_nxt = ST_EXEC;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r     <= ST_IDLE;
            pc_r     <= 32'h0000_0000;
            w0_r     <= 32'h0000_0000;
            addr_r   <= 32'h0000_0000;
            ad_r     <= 32'h0000_0000;
            remain_r <= 10'h000;
            irq_r    <= 1'b0;
            fin_r    <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            pc_r     <= pc_nxt;
            w0_r     <= w0_nxt;
            addr_r   <= addr_nxt;
            ad_r     <= ad_nxt;
            remain_r <= remain_nxt;
            irq_r    <= irq_nxt;
            fin_r    <= fin_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // target response

    logic sel_d_r, sel_d_nxt, par_exp_r, par_exp_nxt, perr_r, perr_nxt;

    // every access completes in the bus clock domain
    assign tgt_trdy_o = tgt_sel;
    assign tgt_stop_o = 1'b0;
    assign perr_o     = perr_r;

    always_comb begin
        sel_d_nxt   = tgt_sel;
        par_exp_nxt = even_par(tgt_ad_i, tgt_cbe_i);
        // parity arrives one clock after its data
        perr_nxt    = sel_d_r && (tgt_par_i != par_exp_r);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sel_d_r   <= 1'b0;
            par_exp_r <= 1'b0;
            perr_r    <= 1'b0;
        end else begin
            sel_d_r   <= sel_d_nxt;
            par_exp_r <= par_exp_nxt;
            perr_r    <= perr_nxt;
        end
    end

    // continuous capture: packer never waits on the initiator

endmodule // atd_dma_channel

/* File: testbench/atd_dma_channel_assertions.sv */
/* port checker for atd_dma_channel.
   assumes one clock domain with srst as its reset. */
module atd_dma_channel_assertions
    import atd_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)(
    input wire logic             clk,
    input wire logic             srst,
    input wire logic             risc_start,
    input wire logic             fetch_req,
    input wire logic [31:0]      fetch_addr,
    input wire logic             fetch_ack,
    input wire logic             bus_gnt,
    input wire logic             frame_o,
    input wire logic             irdy_o,
    input wire logic             ctl_oe,
    input wire logic [31:0]      ad_o,
    input wire logic [3:0]       cbe_o,
    input wire logic             ad_oe,
    input wire logic             trdy_i,
    input wire logic             stop_i,
    input wire logic             tgt_sel,
    input wire logic [31:0]      tgt_ad_i,
    input wire logic [3:0]       tgt_cbe_i,
    input wire logic             tgt_par_i,
    input wire logic             tgt_trdy_o,
    input wire logic             tgt_stop_o,
    input wire logic             perr_o,
    input wire logic             risc_irq,
    input wire logic             overrun,
    input wire logic [CNT_W-1:0] fifo_level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic par_now;
    assign par_now = ^{tgt_ad_i, tgt_cbe_i};
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
////////////////////////////////
    tgt_ready_a: assert property (tgt_sel |-> tgt_trdy_o && !tgt_stop_o)
        else $error("target did not answer at once");
    tgt_nostop_a: assert property (!tgt_stop_o)
        else $error("target signalled stop");
    parity_flag_a: assert property ($past(tgt_sel, 2) |-> perr_o == ($past(par_now, 2) != $past(tgt_par_i)))
        else $error("parity flag wrong");
    fifo_bound_a: assert property (fifo_level <= DEPTH)
        else $error("fifo level above depth");
    fifo_step_a: assert property (fifo_level <= $past(fifo_level) + 1)
        else $error("fifo level jumped");
    addr_phase_a: assert property ($rose(frame_o) |-> !irdy_o && ad_oe && cbe_o == PCI_MEM_WRITE && $past(bus_gnt))
        else $error("bad address phase");
    data_hold_a: assert property (irdy_o && !trdy_i && !stop_i |=> irdy_o && $stable(ad_o))
        else $error("data phase not held");
    burst_end_a: assert property (irdy_o && trdy_i && !frame_o |=> !irdy_o && !frame_o)
        else $error("bus not released");
    irq_pulse_a: assert property (risc_irq |=> !risc_irq)
        else $error("irq longer than a cycle");
    overrun_keep_a: assert property (overrun && !risc_start |=> overrun)
        else $error("overrun flag lost");
    fetch_hold_a: assert property (fetch_req && !fetch_ack |=> fetch_req && $stable(fetch_addr))
        else $error("fetch request dropped");
    bus_drive_a: assert property (ad_oe == ctl_oe && ctl_oe == (frame_o || irdy_o))
        else $error("bus drive enable wrong");
    data_bytes_a: assert property (irdy_o |-> cbe_o == BYTES_ALL)
        else $error("data phase byte enables wrong");
    frame_low_a: assert property (irdy_o && !frame_o |=> !frame_o)
        else $error("frame raised again in burst");
    cover property (irdy_o && trdy_i && !frame_o);
    cover property (irdy_o && stop_i && !trdy_i);
    cover property (perr_o);
    cover property ($rose(overrun));
endmodule // atd_dma_channel_assertions

bind atd_dma_channel atd_dma_channel_assertions #(.DEPTH(DEPTH)) u_chk (.*);

/* File: testbench/atd_host_model.sv */
/* host bridge and memory: serves the program, grants the bus, takes bursts.
   assumes the bench steers slow, retry and hold. */
module atd_host_model (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        slow,
    input  wire logic        retry,
    input  wire logic        hold,
    input  wire logic        fetch_req,
    input  wire logic [31:0] fetch_addr,
    output logic             fetch_ack,
    output logic [31:0]      fetch_data,
    input  wire logic        bus_req,
    output logic             bus_gnt,
    input  wire logic        frame_o,
    input  wire logic        irdy_o,
    input  wire logic [31:0] ad_o,
    output logic             trdy_i,
    output logic             stop_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] prog [8];
    logic [31:0] got [$];
    logic [31:0] adr [$];
    int          cnt [$];
    logic        tick;
    logic        go;
    assign go = !srst && (!slow || tick);
    initial begin
        {fetch_ack, bus_gnt, trdy_i, stop_i, tick} = 5'h0;
        fetch_data = 32'h0;
    end
    always @(posedge clk) begin
        tick <= ~tick;
        fetch_ack <= go && fetch_req && !fetch_ack;
        // idle data line inverts every clock, starting from the last word
        fetch_data <= (fetch_req && !fetch_ack) ? prog[fetch_addr[4:2]] : ~fetch_data;
        bus_gnt <= !srst && !hold && bus_req;
        trdy_i <= go && !retry && irdy_o;
        stop_i <= !srst && retry && irdy_o && !stop_i;
        if (irdy_o && trdy_i) got.push_back(ad_o);
        if (frame_o && !irdy_o) begin
            adr.push_back(ad_o);
            cnt.push_back(got.size());
        end
    end
endmodule // atd_host_model

/* File: testbench/atd_dma_channel_tb.sv */
/* self-checking bench for atd_dma_channel with random data from seed 3.
   assumes the host model stands on the bus side. */
module atd_dma_channel_tb;
    import atd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] DEST = 32'h0000_2000;
    logic clk = 0, srst = 1, risc_run = 0, risc_start = 0, smp_wide = 0;
    logic smp_valid = 0, ser_valid = 0, par_valid = 0, tgt_sel = 0, tgt_par_i = 0;
    logic slow = 0, retry = 0, hold = 0, rok = 0;
    logic [1:0]           mode = 2'h0;
    logic [15:0]          smp_data = 16'h0;
    logic [SER_LANES-1:0] ser_data = '0;
    logic [7:0]           par_data = 8'h0;
    logic [31:0]          prog_base = 32'h0000_0100, tgt_ad_i = 32'h0, fetch_addr, fetch_data, ad_o;
    logic [3:0]           tgt_cbe_i = 4'h0, cbe_o;
    logic [CNT_W-1:0]     fifo_level;
    logic fetch_req, fetch_ack, bus_req, bus_gnt, frame_o, irdy_o, ctl_oe, ad_oe, trdy_i, stop_i;
    logic tgt_trdy_o, tgt_stop_o, perr_o, risc_irq, overrun, busy;
    int seed = 3, miscompares = 0, checked = 0, irqs = 0;
    logic [31:0] exq [$];

    always #20 clk = ~clk;
    always @(posedge clk) if (risc_irq) irqs <= irqs + 1;
    always @(posedge clk) retry <= rok && ($random(seed) % 6 == 0);

    atd_dma_channel dut (.*);
    atd_host_model  h (.*);
////////////////////////////////
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] exp_addr(int n);
        return DEST + 32'(4 * n);
    endfunction

    task automatic complete_run;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic ran_out;
        miscompares++;
        $display("FAIL %0t wait ran out", $time);
        complete_run();
    endtask

    task automatic unit(int k, logic [15:0] d);
        @(posedge clk);
        smp_data <= d;
        par_data <= d[15:8];
        ser_data <= d[1:0];
        smp_valid <= k < 2;
        ser_valid <= k == 2;
        par_valid <= k == 3;
        @(posedge clk);
        {smp_valid, ser_valid, par_valid} <= 3'h0;
    endtask

    // little-endian bytes; serial bits msb first
    task automatic feed(int k, logic [31:0] w);
        for (int i = 0; i < 16; i++) begin
            if (k == 2) unit(k, 16'(w[8*(i/4)+6-2*(i%4)+:2]));
            else if (k == 1 && i < 2) unit(k, w[16*i+:16]);
            else if (k != 1 && i < 4) unit(k, {w[8*i+:8], 8'($random(seed))});
        end
    endtask

    task automatic run(int k, int nw, int nf, logic hl);
        int n0, t;
        logic [31:0] w;
        n0 = irqs;
        h.got.delete();
        h.adr.delete();
        h.cnt.delete();
        exq.delete();
        h.prog[0] = {OP_WRITE, 3'h0, 1'b1, 12'h0, 12'(4 * nw)};
        h.prog[1] = DEST;
        // after the write: halt, or jump to itself until run drops
        h.prog[2] = hl ? {OP_HALT, 28'h0} : {OP_JUMP, 28'h0};
        h.prog[3] = prog_base + DWORD_STEP + DWORD_STEP;
        @(posedge clk);
        hold <= hl;
        slow <= 1'($random(seed));
        mode <= (k < 2) ? MODE_AUDIO : (k == 2) ? MODE_SERIAL : MODE_PARALLEL;
        smp_wide <= k == 1;
        risc_start <= 1;
        @(posedge clk);
        risc_start <= 0;
        #1 chk(overrun, 0);
        for (int i = 0; i < nf; i++) begin
            w = $random(seed);
            if (i < nw) exq.push_back(w);
            feed(k, w);
        end
        if (hl) begin
            repeat (2) @(posedge clk);
            #1 chk(overrun, 1);
            chk(fifo_level, FIFO_DEPTH);
            @(posedge clk) hold <= 0;
        end
        for (t = 0; t < 5000 && (h.got.size() < nw || irqs == n0); t++) @(posedge clk);
        if (t == 5000) ran_out();
        @(posedge clk) risc_run <= 0;
        for (t = 0; t < 50 && busy !== 1'b0; t++) @(posedge clk);
        if (t == 50) ran_out();
        risc_run <= 1;
        chk(h.got.size(), nw);
        chk(irqs - n0, 1);
        for (int i = 0; i < nw; i++) chk(h.got[i], exq[i]);
        for (int i = 0; i < h.adr.size(); i++) chk(h.adr[i], exp_addr(h.cnt[i]));
        $display("test mode %0d words %0d done", k, nw);
    endtask

    task automatic parity_run;
        logic e [12];
        logic p [12];
        logic [31:0] a;
        logic [3:0] c;
        for (int j = 0; j < 12; j++) begin
            @(posedge clk);
            a = $random(seed);
            c = 4'($random(seed));
            e[j] = ^{a, c};
            p[j] = 1'($random(seed));
            tgt_sel <= 1;
            tgt_ad_i <= a;
            tgt_cbe_i <= c;
            tgt_par_i <= p[j];
            #1 chk({tgt_trdy_o, tgt_stop_o}, 2'h2);
            if (j > 1) chk(perr_o, e[j-2] != p[j-1]);
        end
        @(posedge clk) tgt_sel <= 0;
        $display("test parity done");
    endtask
////////////////////////////////
    initial begin
        int n;
        repeat (20) @(posedge clk);
        srst <= 0;
        risc_run <= 1;
        parity_run();
        run(0, 35, 36, 1);
        for (int r = 0; r < 16; r++) begin
            n = (r < 4) ? 1 : 2 + $unsigned($random(seed)) % 11;
            rok <= r > 7;
            run(r % 4, n, n, 0);
        end
        complete_run();
    end
endmodule // atd_dma_channel_tb
